/* stc_map.vh */
// register offsets, field positions, reset values and timing counts
`ifndef STC_MAP_VH
`define STC_MAP_VH
`define STC_ADDR_W 8
`define STC_OFF_CONTROL 8'h00
`define STC_OFF_LOW 8'h04
`define STC_OFF_HIGH 8'h08
`define STC_OFF_STATUS 8'h0C
`define STC_OFF_CLEAR 8'h10
`define STC_OFF_ENABLE 8'h14
`define STC_CTRL_RESET 8'h00
`define STC_BIT_WIDE 7
`define STC_BIT_TB_HI 6
`define STC_BIT_PS_HI 5
`define STC_BIT_PS_LO 4
`define STC_BIT_TB_LO 3
`define STC_BIT_NOSYNC 2
`define STC_BIT_EXTSRC 1
`define STC_BIT_ON 0
`define STC_BIT_OVF 0
`define STC_INSTR_DIV 4
`endif

/* stc_prescaler.v */
// input clock prescaler: passes one tick in 1, 2, 4 or 8
`timescale 1ns/10ps
module stc_prescaler #(
	parameter WIDTH = 3
) (
	input wire i_clk,
	input wire i_rst_n,
	input wire i_tick,
	input wire [1:0] i_sel,
	input wire i_clear,
	output wire o_tick
);
	reg [WIDTH-1:0] count;
	wire [WIDTH-1:0] last;

	// sel 00 -> 0, 01 -> 1, 10 -> 3, 11 -> 7
	assign last = (i_sel == 2'h0) ? {WIDTH{1'b0}} :
		(i_sel == 2'h1) ? {{(WIDTH-1){1'b0}}, 1'b1} :
		(i_sel == 2'h2) ? {{(WIDTH-2){1'b0}}, 2'h3} : {WIDTH{1'b1}};
	assign o_tick = i_tick && (count >= last);

	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count <= {WIDTH{1'b0}};
		end else if (i_clear) begin
			count <= {WIDTH{1'b0}};
		end else if (o_tick) begin
			count <= {WIDTH{1'b0}};
		end else if (i_tick) begin
			count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end
endmodule // stc_prescaler

/* stc_timer.v */
// sixteen-bit timer/counter with byte access, prescaler and apb registers
`timescale 1ns/10ps
`include "stc_map.vh"

// Overview of operation
// - the count is 16 bits, reached by software as a low and a high byte.
// - a special event trigger clears the count to zero.
// - control bit 7 chooses one 16-bit access or two independent bytes.
// - control bits 6 and 3 pick which timer feeds each capture unit.
// - control bits 5-4 divide the input clock by 1, 2, 4 or 8.
// - with the external source, bit 2 high skips synchronising the pin.
// - with the internal source bit 2 is ignored and fosc/4 is counted.
// - bit 1 picks the external pin or fosc/4, counting after a fall.
// - bit 0 high lets the count advance, low stops it.
// - the count wraps from FFFFh to 0000h and sets the overflow flag.
// - in wide mode a low read latches the high byte, a low write loads it.
// - only low-byte writes clear the prescaler.
// - a low write, or a high write outside wide mode, beats a coincident trigger; a trigger never sets overflow.
module stc_timer #(
	parameter PRESCALE_W = 3
) (
	input wire I_CLOCK,
	input wire I_RST_N,
	input wire I_PSEL,
	input wire I_PENABLE,
	input wire I_PWRITE,
	input wire [`STC_ADDR_W-1:0] I_PADDR,
	input wire [31:0] I_PWDATA,
	output reg [31:0] O_PRDATA,
	output wire O_PREADY,
	output wire O_PSLVERR,
	input wire I_EXTERNAL_CLOCK_PIN,
	input wire I_SPECIAL_TRIG,
	output reg [15:0] O_COUNT,
	output wire O_UNIT_ONE_USES_THIS,
	output wire O_UNIT_TWO_USES_THIS,
	output wire O_IRQ
);
	reg [7:0] control;
	reg [7:0] high_buffer;
	reg overflow_flag;
	reg overflow_irq_enable;
	reg [1:0] instr_div;
	reg sync_1;
	reg sync_2;
	reg sync_prev;
	reg raw_prev;
	reg armed;
	reg [15:0] next_count;
	reg [31:0] next_rdata;
	reg mapped;
	wire wide_access_enable;
	wire [1:0] timebase_sel;
	wire [1:0] prescale_sel;
	wire ext_sync_disable;
	wire clock_source_select;
	wire count_enable;
	wire setup;
	wire access;
	wire wr;
	wire wr_low;
	wire wr_high;
	wire instr_tick;
	wire ext_cur;
	wire ext_prev;
	wire ext_rise;
	wire ext_fall;
	wire src_tick;
	wire count_tick;
	wire wrap;

	assign wide_access_enable = control[`STC_BIT_WIDE];
	assign timebase_sel = {control[`STC_BIT_TB_HI], control[`STC_BIT_TB_LO]};
	assign prescale_sel = {control[`STC_BIT_PS_HI], control[`STC_BIT_PS_LO]};
	assign ext_sync_disable = control[`STC_BIT_NOSYNC];
	assign clock_source_select = control[`STC_BIT_EXTSRC];
	assign count_enable = control[`STC_BIT_ON];

	// 1x: this timer for both units, 01: unit two only, 00: neither
	assign O_UNIT_ONE_USES_THIS = timebase_sel[1];
	assign O_UNIT_TWO_USES_THIS = timebase_sel[1] | timebase_sel[0];

	// zero-wait slave: every access phase completes at once
	assign setup = I_PSEL && !I_PENABLE;
	assign access = I_PSEL && I_PENABLE;
	assign O_PREADY = 1'b1;
	assign wr = access && I_PWRITE && !O_PSLVERR;
	assign wr_low = wr && (I_PADDR == `STC_OFF_LOW);
	assign wr_high = wr && (I_PADDR == `STC_OFF_HIGH);

	always @* begin
		if (I_PADDR == `STC_OFF_CONTROL) begin
			mapped = 1'b1;
		end else if (I_PADDR == `STC_OFF_LOW) begin
			mapped = 1'b1;
		end else if (I_PADDR == `STC_OFF_HIGH) begin
			mapped = 1'b1;
		end else if (I_PADDR == `STC_OFF_STATUS) begin
			mapped = 1'b1;
		end else if (I_PADDR == `STC_OFF_CLEAR) begin
			mapped = 1'b1;
		end else if (I_PADDR == `STC_OFF_ENABLE) begin
			mapped = 1'b1;
		end else begin
			mapped = 1'b0;
		end
	end
	assign O_PSLVERR = access && !mapped;

	// instruction clock: one enable in every four system clocks
	assign instr_tick = ({30'h0, instr_div} == (`STC_INSTR_DIV - 1));

	always @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			instr_div <= 2'h0;
		end else begin
			instr_div <= instr_div + 2'h1;
		end
	end

	// pin sampling: synchronised path adds two flops of latency
	always @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			sync_1 <= 1'b0;
			sync_2 <= 1'b0;
			sync_prev <= 1'b0;
			raw_prev <= 1'b0;
		end else begin
			sync_1 <= I_EXTERNAL_CLOCK_PIN;
			sync_2 <= sync_1;
			sync_prev <= sync_2;
			raw_prev <= I_EXTERNAL_CLOCK_PIN;
		end
	end

	assign ext_cur = ext_sync_disable ? I_EXTERNAL_CLOCK_PIN : sync_2;
	assign ext_prev = ext_sync_disable ? raw_prev : sync_prev;
	assign ext_rise = ext_cur && !ext_prev;
	assign ext_fall = !ext_cur && ext_prev;

	// a high pin at switch-on must not give a false first edge
	always @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			armed <= 1'b0;
		end else if (!clock_source_select || !count_enable) begin
			armed <= 1'b0;
		end else if (ext_fall) begin
			armed <= 1'b1;
		end
	end

	// internal source never looks at the sync bit
	assign src_tick = clock_source_select ? (armed && ext_rise)
		: instr_tick;

	// prescaler sees no ticks while stopped, so it holds too
	stc_prescaler #(
		.WIDTH(PRESCALE_W)
	) u_prescaler (
		.i_clk(I_CLOCK),
		.i_rst_n(I_RST_N),
		.i_tick(src_tick && count_enable),
		.i_sel(prescale_sel),
		.i_clear(wr_low),
		.o_tick(count_tick)
	);

	assign wrap = count_tick && (O_COUNT == 16'hFFFF) && !wr_low &&
		!(wr_high && !wide_access_enable);

	always @* begin
		next_count = O_COUNT;
		if (wr_low) begin
			if (wide_access_enable) begin
				next_count = {high_buffer, I_PWDATA[7:0]};
			end else begin
				next_count = {O_COUNT[15:8], I_PWDATA[7:0]};
			end
		end else if (wr_high && !wide_access_enable) begin
			next_count = {I_PWDATA[7:0], O_COUNT[7:0]};
		end else if (I_SPECIAL_TRIG) begin
			next_count = 16'h0000;
		end else if (count_tick) begin
			next_count = O_COUNT + 16'h0001;
		end
	end

	// a wide high write only touches the buffer, so it does not beat a trigger
	always @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_COUNT <= 16'h0000;
		end else begin
			O_COUNT <= next_count;
		end
	end

	always @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			high_buffer <= 8'h00;
		end else if (wr_high && wide_access_enable) begin
			high_buffer <= I_PWDATA[7:0];
		end else if (setup && !I_PWRITE && wide_access_enable &&
			I_PADDR == `STC_OFF_LOW) begin
			high_buffer <= O_COUNT[15:8];
		end
	end

	always @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			control <= `STC_CTRL_RESET;
			overflow_irq_enable <= 1'b0;
		end else if (wr && I_PADDR == `STC_OFF_CONTROL) begin
			control <= I_PWDATA[7:0];
		end else if (wr && I_PADDR == `STC_OFF_ENABLE) begin
			overflow_irq_enable <= I_PWDATA[`STC_BIT_OVF];
		end
	end

	// set wins over a clear in the same cycle; trigger resets never set it
	always @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			overflow_flag <= 1'b0;
		end else if (wrap && !I_SPECIAL_TRIG) begin
			overflow_flag <= 1'b1;
		end else if (wr && I_PADDR == `STC_OFF_CLEAR &&
			I_PWDATA[`STC_BIT_OVF]) begin
			overflow_flag <= 1'b0;
		end
	end

	assign O_IRQ = overflow_flag && overflow_irq_enable;

	// read data is captured in the setup cycle, with the low-read latch
	always @* begin
		next_rdata = 32'h00000000;
		if (I_PADDR == `STC_OFF_CONTROL) begin
			next_rdata[7:0] = control;
		end else if (I_PADDR == `STC_OFF_LOW) begin
			next_rdata[7:0] = O_COUNT[7:0];
		end else if (I_PADDR == `STC_OFF_HIGH) begin
			next_rdata[7:0] = wide_access_enable ? high_buffer
				: O_COUNT[15:8];
		end else if (I_PADDR == `STC_OFF_STATUS) begin
			next_rdata[`STC_BIT_OVF] = overflow_flag;
		end else if (I_PADDR == `STC_OFF_ENABLE) begin
			next_rdata[`STC_BIT_OVF] = overflow_irq_enable;
		end
	end

	always @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_PRDATA <= 32'h00000000;
		end else if (setup && !I_PWRITE) begin
			O_PRDATA <= next_rdata;
		end
	end
endmodule // stc_timer

/* stc_timer_monitor.sv */
// checker on the timer ports, bound into every timer
`timescale 1ns/10ps
`include "stc_map.vh"
module stc_timer_monitor(
	input wire I_CLOCK,
	input wire I_RST_N,
	input wire I_PSEL,
	input wire I_PENABLE,
	input wire I_PWRITE,
	input wire [`STC_ADDR_W-1:0] I_PADDR,
	input wire [31:0] I_PWDATA,
	input wire I_SPECIAL_TRIG,
	input wire [15:0] O_COUNT,
	input wire O_UNIT_ONE_USES_THIS,
	input wire O_UNIT_TWO_USES_THIS,
	input wire O_IRQ
);
	reg [7:0] ctrl;
	reg [7:0] hbuf;
	wire acc = I_PSEL & I_PENABLE & I_PWRITE;
	wire wlo = acc && I_PADDR == `STC_OFF_LOW;
	wire whi = acc && I_PADDR == `STC_OFF_HIGH;
	// shadow of control and of the wide-mode buffer, fed by writes and, for the buffer, by wide-mode low reads
	always @(posedge I_CLOCK or negedge I_RST_N)
		if (!I_RST_N) begin
			ctrl <= 8'h00;
			hbuf <= 8'h00;
		end else begin
			if (acc && I_PADDR == `STC_OFF_CONTROL)
				ctrl <= I_PWDATA[7:0];
			if (whi && ctrl[7])
				hbuf <= I_PWDATA[7:0];
			else if (I_PSEL && !I_PENABLE && !I_PWRITE && ctrl[7] &&
				I_PADDR == `STC_OFF_LOW)
				hbuf <= O_COUNT[15:8];
		end
	default clocking @(posedge I_CLOCK); endclocking
	default disable iff (!I_RST_N);
	a_unit_one: assert property (O_UNIT_ONE_USES_THIS == ctrl[6])
		else $error("unit one source wrong");
	a_unit_two: assert property (
		O_UNIT_TWO_USES_THIS == (ctrl[6] | ctrl[3])) else $error("unit two");
	a_trig_clear: assert property (
		I_SPECIAL_TRIG && !wlo && !(whi && !ctrl[7]) |=> O_COUNT == 16'h0000)
		else $error("trigger did not clear");
	a_write_wins: assert property (wlo && !ctrl[7] |=>
		O_COUNT[7:0] == $past(I_PWDATA[7:0])) else $error("low write lost");
	a_wide_load: assert property (wlo && ctrl[7] |=>
		O_COUNT == {hbuf, $past(I_PWDATA[7:0])}) else $error("wide load");
	a_count_step: assert property (
		$changed(O_COUNT) && !$past(wlo | whi | I_SPECIAL_TRIG) |->
		O_COUNT == $past(O_COUNT) + 16'h0001) else $error("bad step");
	a_stop_hold: assert property (
		!ctrl[0] && !wlo && !whi && !I_SPECIAL_TRIG |=> $stable(O_COUNT))
		else $error("stopped count moved");
	a_irq_cause: assert property ($rose(O_IRQ) |->
		$past(O_COUNT) == 16'hFFFF && !$past(I_SPECIAL_TRIG) ||
		$past(acc && I_PADDR == `STC_OFF_ENABLE)) else $error("bad irq");
	cover property (wlo && ctrl[7]);
	cover property (wlo && I_SPECIAL_TRIG);
	cover property ($rose(O_IRQ));
endmodule // stc_timer_monitor
bind stc_timer stc_timer_monitor u_mon(.*);

/* stc_ext_clock_model.sv */
// far-side model: external count clock, idle high between bursts
`timescale 1ns/10ps
module stc_ext_clock_model(
	input wire i_clk,
	input wire i_go,
	output reg o_pin // never the system clock source
);
	reg [1:0] ph;
	initial o_pin = 1'h1;
	// a burst opens with a fall, so each later rise is a counted edge
	always @(posedge i_clk) begin
		if (!i_go) begin
			ph <= 2'h0;
			o_pin <= 1'h1;
		end else if (ph == 2'h2) begin
			ph <= 2'h0;
			o_pin <= ~o_pin;
		end else
			ph <= ph + 2'h1;
	end
endmodule // stc_ext_clock_model

/* tb_sixteen_bit_timer_counter.sv */
// self-checking bench for the sixteen-bit timer/counter
`timescale 1ns/10ps
`include "stc_map.vh"
module tb_sixteen_bit_timer_counter;
	reg clk = 1'h0, rst_n = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
	reg trig = 1'h0, go = 1'h0, tw = 1'h0, rerr;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h0, rd;
	reg [15:0] mc, p;
	wire [31:0] prdata;
	wire [15:0] cnt;
	wire ready, err, u1, u2, irq, pin;
	integer bad_count = 0, num_checks = 0, cyc = 0, seed = 32'h16daa416;
	integer i, n;
	stc_timer i_dut(.I_CLOCK(clk), .I_RST_N(rst_n), .I_PSEL(psel),
		.I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
		.I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(ready),
		.O_PSLVERR(err), .I_EXTERNAL_CLOCK_PIN(pin),
		.I_SPECIAL_TRIG(trig), .O_COUNT(cnt), .O_UNIT_ONE_USES_THIS(u1),
		.O_UNIT_TWO_USES_THIS(u2), .O_IRQ(irq));
	stc_ext_clock_model i_pin(.i_clk(clk), .i_go(go), .o_pin(pin));
	always #2 clk = ~clk;
	always @(posedge clk)
		if (++cyc > 20000) begin
			bad_count++;
			wrap_up;
		end
	task chk(input [31:0] seen, input [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task apb(input w, input [7:0] a, input [31:0] d);
		psel <= 1'h1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'h1;
		trig <= tw;
		@(posedge clk);
		while (ready !== 1'h1) @(posedge clk);
		rd = prdata;
		rerr = err;
		psel <= 1'h0;
		pen <= 1'h0;
		trig <= 1'h0;
		@(posedge clk);
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		apb(0, `STC_OFF_CONTROL, 0);
		chk(rd, 0);
		apb(0, 8'h18, 0);
		chk({rerr, rd[7:0]}, 9'h100);
		for (i = 0; i < 4; i++) begin
			apb(1, `STC_OFF_CONTROL, {1'h0, i[1], 2'h0, i[0], 3'h0});
			chk({u1, u2}, {i[1], i[1] | i[0]});
		end
		mc = $random(seed);
		apb(1, `STC_OFF_HIGH, mc[15:8]);
		apb(1, `STC_OFF_LOW, mc[7:0]);
		repeat (20) @(posedge clk);
		apb(0, `STC_OFF_HIGH, 0);
		chk(rd, mc[15:8]);
		chk(cnt, mc);
		tw = 1'h1;
		apb(1, `STC_OFF_LOW, 8'h5A);
		tw = 1'h0;
		chk(cnt, {mc[15:8], 8'h5A});
		trig <= 1'h1;
		@(posedge clk);
		trig <= 1'h0;
		@(posedge clk);
		chk(cnt, 0);
		apb(0, `STC_OFF_STATUS, 0);
		chk(rd, 0);
		mc = $random(seed);
		apb(1, `STC_OFF_CONTROL, 8'h80);
		apb(1, `STC_OFF_HIGH, mc[15:8]);
		chk(cnt, 0);
		apb(1, `STC_OFF_LOW, mc[7:0]);
		chk(cnt, mc);
		apb(0, `STC_OFF_LOW, 0);
		apb(0, `STC_OFF_HIGH, 0);
		chk(rd, mc[15:8]);
		// bit 2 set on the internal source must change nothing
		for (i = 0; i < 4; i++) begin
			apb(1, `STC_OFF_CONTROL, {i[1:0], 4'h5});
			p = cnt;
			while (cnt === p) @(posedge clk);
			p = cnt;
			for (n = 0; cnt === p; n++) @(posedge clk);
			chk(n, 4 << i);
		end
		apb(1, `STC_OFF_CONTROL, 8'h01);
		apb(1, `STC_OFF_ENABLE, 1);
		apb(1, `STC_OFF_LOW, 8'hF0);
		apb(1, `STC_OFF_HIGH, 8'hFF);
		while (cnt !== 16'h0000) @(posedge clk);
		chk(irq, 1);
		apb(1, `STC_OFF_ENABLE, 0);
		chk(irq, 0);
		apb(0, `STC_OFF_STATUS, 0);
		chk(rd, 1);
		apb(1, `STC_OFF_CLEAR, 1);
		apb(1, `STC_OFF_ENABLE, 1);
		chk(irq, 0);
		for (i = 0; i < 2; i++) begin
			apb(1, `STC_OFF_CONTROL, {i[0], 2'h3});
			apb(1, `STC_OFF_LOW, 0);
			apb(1, `STC_OFF_HIGH, 0);
			go <= 1'h1;
			repeat (12 + 6 * i) @(posedge clk);
			go <= 1'h0;
			repeat (5) @(posedge clk);
			chk(cnt, 2 + i);
		end
		wrap_up;
	end
endmodule // tb_sixteen_bit_timer_counter
